// File: pkg/sleia_params.svh
`ifndef SLEIA_PARAMS_SVH
`define SLEIA_PARAMS_SVH
// register offsets
`define SLEIA_ADDR_W             11
`define SLEIA_OFS_DISP_LANES     11'h046d
`define SLEIA_OFS_NIT_LANES      11'h046e
`define SLEIA_OFS_UCC_LANES      11'h046f
`define SLEIA_OFS_SYMLOCK_LANES  11'h0470
`define SLEIA_OFS_FRAME_LANES    11'h0471
`define SLEIA_OFS_CHKSUM_LANES   11'h0472
`define SLEIA_OFS_ALIGN_LANES    11'h0473
`define SLEIA_OFS_IRQ_VECTOR     11'h047a
`define SLEIA_OFS_THRESHOLD      11'h047c
// field positions in the enable/summary register
`define SLEIA_BIT_DISP           7
`define SLEIA_BIT_NIT            6
`define SLEIA_BIT_UCC            5
`define SLEIA_BIT_RSVD           4
`define SLEIA_BIT_ALIGN          3
`define SLEIA_BIT_CHKSUM         2
`define SLEIA_BIT_FRAME          1
`define SLEIA_BIT_SYMLOCK        0
// bit of a lane status register that clears its interrupt
`define SLEIA_BIT_LANE_CLR       7
// reset values
`define SLEIA_RST_ENABLE         8'h00
`define SLEIA_RST_THRESHOLD      8'hff
`define SLEIA_RST_LANES          8'h00
`endif

// File: pkg/sleia_pkg.sv
package sleia_pkg;
  typedef logic [7:0] sleia_byte_t;
  typedef enum logic [1:0] {
    SLEIA_CNT_DISP,
    SLEIA_CNT_NIT,
    SLEIA_CNT_UCC
  } sleia_cnt_e;
endpackage : sleia_pkg

// File: rtl/sleia_top.sv
// Overview of operation
// - disparity enable plus threshold hit lowers interrupt
// - invalid-symbol enable plus threshold hit lowers interrupt
// - stray-control enable plus threshold hit lowers interrupt
// - alignment enable plus lane-sync failure lowers interrupt
// - checksum enable plus checksum mismatch lowers interrupt
// - frame enable plus frame-sync failure lowers interrupt
// - symbol-lock enable plus lock failure lowers interrupt
// - summary bit 7: any lane disparity threshold
// - summary bit 6: any lane invalid-symbol threshold
// - summary bit 5: any lane stray-control threshold
// - summary bit 3: any lane alignment failure
// - summary bit 2: any lane checksum mismatch
// - summary bit 1: any lane frame failure
// - summary bit 0: any lane lock failure
// - errors counted per lane against programmable threshold
`timescale 1ns/100ps
`include "sleia_params.svh"
module sleia_top #(
  parameter int LANES = 7
) (
  input  wire logic                       clock,         // receiver clock, 100 MHz
  input  wire logic                       resetn,        // async reset, active low
  input  wire logic [`SLEIA_ADDR_W-1:0]   reg_addr,      // register address
  input  wire logic                       reg_wr,        // write strobe, one cycle
  input  wire logic                       reg_rd,        // read strobe, one cycle
  input  wire logic [7:0]                 reg_wdata,     // write data
  output logic      [7:0]                 reg_rdata,     // read data, valid cycle after reg_rd
  input  wire logic [LANES-1:0]           disp_err,      // per-lane disparity error pulse
  input  wire logic [LANES-1:0]           nit_err,       // per-lane not-in-table pulse
  input  wire logic [LANES-1:0]           ucc_err,       // per-lane stray control pulse
  input  wire logic [LANES-1:0]           symlock_ok,    // per-lane code group lock level
  input  wire logic [LANES-1:0]           frame_ok,      // per-lane frame sync level
  input  wire logic [LANES-1:0]           chksum_ok,     // per-lane checksum good level
  input  wire logic [LANES-1:0]           align_ok,      // per-lane initial sync level
  output logic                            irq_n          // interrupt, active low
);

  // bit 7 of a lane status byte is the clear strobe, so at most seven lanes fit
  if (LANES < 1 || LANES > 7) begin : g_bad_lanes
    $error("LANES must be 1..7");
  end

  // lane status bytes keep bit 7 free for the interrupt clear strobe
  sleia_pkg::sleia_byte_t enable_r;
  sleia_pkg::sleia_byte_t threshold_r;
  sleia_pkg::sleia_byte_t rdata_r;
  logic                   irq_n_r;
  logic [LANES-1:0]       disp_hit_r, nit_hit_r, ucc_hit_r;
  logic [7:0]             disp_cnt_r [LANES];
  logic [7:0]             nit_cnt_r  [LANES];
  logic [7:0]             ucc_cnt_r  [LANES];

  wire sel_vec  = reg_addr == `SLEIA_OFS_IRQ_VECTOR;
  wire sel_thr  = reg_addr == `SLEIA_OFS_THRESHOLD;
  wire wr_vec   = reg_wr & sel_vec;
  wire wr_thr   = reg_wr & sel_thr;
  wire clr_disp = reg_wr & (reg_addr == `SLEIA_OFS_DISP_LANES) & reg_wdata[`SLEIA_BIT_LANE_CLR];
  wire clr_nit  = reg_wr & (reg_addr == `SLEIA_OFS_NIT_LANES) & reg_wdata[`SLEIA_BIT_LANE_CLR];
  wire clr_ucc  = reg_wr & (reg_addr == `SLEIA_OFS_UCC_LANES) & reg_wdata[`SLEIA_BIT_LANE_CLR];

  // per-lane counters; a hit sticks until software clears it
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire [7:0] d_nxt = disp_cnt_r[g] + {7'h0, disp_err[g] & ~disp_hit_r[g]};
      wire [7:0] n_nxt = nit_cnt_r[g] + {7'h0, nit_err[g] & ~nit_hit_r[g]};
      wire [7:0] u_nxt = ucc_cnt_r[g] + {7'h0, ucc_err[g] & ~ucc_hit_r[g]};
      wire d_hit = d_nxt >= threshold_r;
      wire n_hit = n_nxt >= threshold_r;
      wire u_hit = u_nxt >= threshold_r;
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          disp_cnt_r[g] <= 8'h00;
          nit_cnt_r[g]  <= 8'h00;
          ucc_cnt_r[g]  <= 8'h00;
          disp_hit_r[g] <= 1'b0;
          nit_hit_r[g]  <= 1'b0;
          ucc_hit_r[g]  <= 1'b0;
        end else begin
          // set wins over a clear in the same cycle
          disp_cnt_r[g] <= clr_disp ? {7'h0, disp_err[g]} : d_nxt;
          nit_cnt_r[g]  <= clr_nit ? {7'h0, nit_err[g]} : n_nxt;
          ucc_cnt_r[g]  <= clr_ucc ? {7'h0, ucc_err[g]} : u_nxt;
          disp_hit_r[g] <= (clr_disp ? 1'b0 : disp_hit_r[g]) | (disp_err[g] & d_hit);
          nit_hit_r[g]  <= (clr_nit ? 1'b0 : nit_hit_r[g]) | (nit_err[g] & n_hit);
          ucc_hit_r[g]  <= (clr_ucc ? 1'b0 : ucc_hit_r[g]) | (ucc_err[g] & u_hit);
        end
      end
    end
  endgenerate

  sleia_pkg::sleia_byte_t summary;
  always_comb begin
    summary = 8'h00;
    summary[`SLEIA_BIT_DISP]    = |disp_hit_r;
    summary[`SLEIA_BIT_NIT]     = |nit_hit_r;
    summary[`SLEIA_BIT_UCC]     = |ucc_hit_r;
    summary[`SLEIA_BIT_ALIGN]   = |(~align_ok);
    summary[`SLEIA_BIT_CHKSUM]  = |(~chksum_ok);
    summary[`SLEIA_BIT_FRAME]   = |(~frame_ok);
    summary[`SLEIA_BIT_SYMLOCK] = |(~symlock_ok);
  end

  // one gate covers each enable/flag pair
  wire irq_any = |(summary & enable_r);

  function automatic sleia_pkg::sleia_byte_t pad(input logic [LANES-1:0] v);
    pad = sleia_pkg::sleia_byte_t'(v);
  endfunction : pad

  sleia_pkg::sleia_byte_t rd_mux;
  always_comb begin
    case (reg_addr)
      `SLEIA_OFS_IRQ_VECTOR:    rd_mux = summary;
      `SLEIA_OFS_THRESHOLD:     rd_mux = threshold_r;
      `SLEIA_OFS_DISP_LANES:    rd_mux = pad(disp_hit_r);
      `SLEIA_OFS_NIT_LANES:     rd_mux = pad(nit_hit_r);
      `SLEIA_OFS_UCC_LANES:     rd_mux = pad(ucc_hit_r);
      `SLEIA_OFS_SYMLOCK_LANES: rd_mux = pad(symlock_ok);
      `SLEIA_OFS_FRAME_LANES:   rd_mux = pad(frame_ok);
      `SLEIA_OFS_CHKSUM_LANES:  rd_mux = pad(chksum_ok);
      `SLEIA_OFS_ALIGN_LANES:   rd_mux = pad(align_ok);
      default:                  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_r    <= `SLEIA_RST_ENABLE;
      threshold_r <= `SLEIA_RST_THRESHOLD;
      rdata_r     <= 8'h00;
      irq_n_r     <= 1'b1;
    end else begin
      if (wr_vec) enable_r <= reg_wdata & ~(8'h01 << `SLEIA_BIT_RSVD);
      if (wr_thr) threshold_r <= reg_wdata;
      if (reg_rd) rdata_r <= rd_mux;
      irq_n_r <= ~irq_any;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_n     = irq_n_r;

endmodule : sleia_top

// File: verif/sleia_host.sv
`timescale 1ns/100ps
module sleia_host (
  input wire logic clock, resetn, irq_n, // clock, reset, interrupt line
  output logic [7:0] irq_falls // interrupts taken so far
);
  logic irq_q_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q_r <= 1'b1;
      irq_falls <= 8'h00;
    end else begin
      irq_q_r <= irq_n;
      if (irq_q_r && !irq_n) irq_falls <= irq_falls + 8'h01;
    end
  end
endmodule : sleia_host

// File: verif/sleia_top_chk.sv
`timescale 1ns/100ps
`include "sleia_params.svh"
module sleia_top_chk #(parameter int LANES = 7) (
  input wire logic clock, resetn, reg_wr, reg_rd, irq_n, // control
  input wire logic [`SLEIA_ADDR_W-1:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, reg_rdata, // data
  input wire logic [LANES-1:0] symlock_ok, frame_ok, chksum_ok, align_ok // lane levels
);
  logic [7:0] en_r; // shadow of the write-only enables
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) en_r <= 8'h00;
    else if (reg_wr && reg_addr == `SLEIA_OFS_IRQ_VECTOR) en_r <= reg_wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence vec_rd; reg_rd && reg_addr == `SLEIA_OFS_IRQ_VECTOR; endsequence
  a_lock_irq: assert property (en_r[0] && !(&symlock_ok) |=> !irq_n) else $error("lock");
  a_frame_irq: assert property (en_r[1] && !(&frame_ok) |=> !irq_n) else $error("frame");
  a_chksum_irq: assert property (en_r[2] && !(&chksum_ok) |=> !irq_n) else $error("sum");
  a_align_irq: assert property (en_r[3] && !(&align_ok) |=> !irq_n) else $error("align");
  a_masked_quiet: assert property (en_r == 8'h00 |=> irq_n) else $error("masked irq");
  a_rsvd_zero: assert property (vec_rd |=> !reg_rdata[4]) else $error("bit 4 set");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 11'h0000 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule : sleia_top_chk

// File: verif/sleia_top_test.sv
`timescale 1ns/100ps
`include "sleia_params.svh"
module sleia_top_test;
  logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, irq_n;
  logic [`SLEIA_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, host_irqs;
  logic [3:0][6:0] okv = '1;
  logic [2:0][6:0] ev = '0;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #5 clock = ~clock;
  sleia_top sleia_top_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .disp_err(ev[0]),
    .nit_err(ev[1]), .ucc_err(ev[2]), .symlock_ok(okv[0]), .frame_ok(okv[1]),
    .chksum_ok(okv[2]), .align_ok(okv[3]), .irq_n(irq_n));
  sleia_host sleia_host_inst (.clock(clock), .resetn(resetn), .irq_n(irq_n), .irq_falls(host_irqs));
  task automatic wrap_up;
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clock); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clock); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock); reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic irq(input logic e); // irq_n is registered one cycle behind the enables
    repeat (2) @(posedge clock);
    #1 chk({7'h00, irq_n}, {7'h00, e});
  endtask : irq
  task automatic pulse(input int k, input int n); // n counted error cycles on lane k
    @(posedge clock); ev[k] <= 7'h01 << k;
    repeat (n) @(posedge clock);
    ev[k] <= '0;
  endtask : pulse
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
    wr(`SLEIA_OFS_IRQ_VECTOR, 8'hff);
    irq(1'b1);
    rd(11'h0000, 8'h00);
    wr(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
    for (int b = 0; b < 4; b++) begin
      @(posedge clock); okv[b] <= 7'h7f ^ (7'h01 << b);
      irq(1'b1);
      rd(`SLEIA_OFS_IRQ_VECTOR, 8'h01 << b);
      rd(11'(`SLEIA_OFS_SYMLOCK_LANES + b), 8'h7f ^ (8'h01 << b));
      wr(`SLEIA_OFS_IRQ_VECTOR, 8'h01 << b);
      irq(1'b0);
      wr(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
      @(posedge clock); okv[b] <= 7'h7f;
    end
    wr(`SLEIA_OFS_THRESHOLD, 8'h03);
    rd(`SLEIA_OFS_THRESHOLD, 8'h03);
    for (int k = 0; k < 3; k++) begin
      pulse(k, 2);
      rd(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
      pulse(k, 1);
      rd(`SLEIA_OFS_IRQ_VECTOR, 8'h80 >> k);
      rd(11'(`SLEIA_OFS_DISP_LANES + k), 8'h01 << k);
      wr(`SLEIA_OFS_IRQ_VECTOR, 8'h80 >> k);
      irq(1'b0);
      wr(11'(`SLEIA_OFS_DISP_LANES + k), 8'h80);
      rd(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
      irq(1'b1);
      wr(`SLEIA_OFS_IRQ_VECTOR, 8'h00);
    end
    chk(host_irqs, 8'h07);
    wrap_up();
  end
endmodule : sleia_top_test
bind sleia_top sleia_top_chk #(.LANES(LANES)) sleia_top_chk_inst (.clock(clock), .resetn(resetn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_n(irq_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .symlock_ok(symlock_ok), .frame_ok(frame_ok), .chksum_ok(chksum_ok),
  .align_ok(align_ok));
